// ===== verilog/clock_divider_power_modes.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "clk_pwr_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - CPU tick is the oscillator clock divided by 128 down to 4, codes 0 to 5.
// - A new divider select acts only after 0x69 is written to the apply register.
// - The oscillator clock is the fixed source chosen at power-on.
// - Each program fetch is stretched by 0 to 7 wait ticks, field resets to 7.
// - Power control bit 0 requests idle, bit 1 requests stop.
// - Idle gates only the CPU tick; peripherals and oscillator keep running.
// - Idle ends on a port change or interrupt; hardware clears the idle bit.
// - Stop halts CPU, peripherals and oscillator, keeping all stored state.
// - Stop ends only on a port change, never an interrupt; stop bit clears.
// - After reset execution waits 2048 fast plus 5 slow oscillator periods.
// - Wake from stop waits 64 fast plus 5 slow oscillator periods.
// - After warm-up the CPU runs at the divided rate in normal mode.
// - Each port 1 wake enable bit allows wake from its pin when set.
// - Port 0 changes always wake, with no enable.
module clock_divider_power_modes
    import clk_pwr_pkg::*;
(
    // Clock (the fixed oscillator clock) and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Wake sources, and the slow oscillator that times the warm-up.
    input wire logic [7:0] port0_in,
    input wire logic [7:0] port1_in,
    input wire logic internal_slow_oscillator,
    input wire logic irq_event,
    // CPU and program memory side.
    input wire logic fetch_req,
    output logic fetch_done,
    output logic [2:0] fetch_wait_cycles,
    output logic cpu_tick,
    output logic cpu_run,
    // Power domain controls.
    output logic periph_run,
    output logic osc_run,
    output pwr_state_t pwr_state
);
    import clk_pwr_pkg::*;

    core_state_t r;
    core_state_t n;
    logic [16:0] pin_stable;
    logic [16:0] pin_change;
    logic wake_pin;
    logic slow_edge;
    logic [7:0] ratio;
    logic [6:0] term;
    logic [7:0] idx;
    logic hit;
    logic wr_en;
    logic setup;
    logic [31:0] rd_mux;
    logic apply_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for both ports and the slow oscillator.
    pin_change_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pins({internal_slow_oscillator, port1_in, port0_in}),
        .stable(pin_stable),
        .change(pin_change)
    );

    // Wake decode: port 0 always, port 1 through its enables.
    assign wake_pin = (|pin_change[7:0]) | (|(pin_change[15:8] & r.p1w));
    assign slow_edge = pin_change[16] & pin_stable[16];

    ////////////////////////////////////////////////////////////////////////////
    // Divider ratio from the active code: 128 shifted right by the code.
    assign ratio = `RATIO_MAX >> r.div_act;
    assign term = 7'(ratio - 8'h01);

    // Bus decode; the word index is the byte address over four.
    assign idx = paddr[9:2];
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & hit;
    assign apply_hit = wr_en && (idx == `IDX_DIV_APPLY) && (pwdata[7:0] == `APPLY_CODE);

    // Address decode and read multiplexer; unmapped words read as zero.
    always_comb
    begin
        hit = 1'b1;
        rd_mux = '0;
        if (paddr[11:10] != 2'h0)
            hit = 1'b0;
        else
        begin
            case (idx)
                `IDX_FETCH_WAIT:
                    rd_mux[7:0] = {1'b0, r.fw, `FW_LOW_READ};
                `IDX_DIV_SELECT:
                    rd_mux[`DIV_MSB:0] = r.div_sel;
                `IDX_DIV_APPLY:
                    rd_mux = '0;
                `IDX_PWR_CTRL:
                    rd_mux[`PC_GF0_BIT:0] = {r.gf0, r.stop_bit, r.idle_bit};
                `IDX_P1_WAKE:
                    rd_mux[7:0] = r.p1w;
                default:
                    hit = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for divider, fetch stretch, power states and registers.
    always_comb
    begin
        n = r;
        n.tick = 1'b0;
        n.fetch_done = 1'b0;

        // Divider runs while the oscillator runs; the tick is gated outside run.
        if ((r.st == ST_RUN) || (r.st == ST_IDLE))
        begin
            if (r.div_cnt >= term)
            begin
                n.div_cnt = '0;
                // No tick once a power bit is set, so none leaks into idle or stop.
                n.tick = (r.st == ST_RUN) && !r.idle_bit && !r.stop_bit;
            end
            else
                n.div_cnt = 7'(r.div_cnt + 7'h01);
        end

        // Cycles since the last tick, for the spacing check.
        n.gap = r.tick ? 8'h01 : ((r.gap == 8'hFF) ? r.gap : 8'(r.gap + 8'h01));
        n.gap_ok = (r.tick | r.gap_ok) & (r.st == ST_RUN);

        // Fetch stretch counts CPU ticks; done on the tick after the waits.
        if (fetch_req && !r.fetch_busy)
        begin
            n.fetch_busy = 1'b1;
            n.fw_cnt = r.fw;
            n.fticks = '0;
        end
        else if (r.fetch_busy && r.tick)
        begin
            n.fticks = 4'(r.fticks + 4'h1);
            if (r.fw_cnt == 3'h0)
            begin
                n.fetch_done = 1'b1;
                n.fetch_busy = 1'b0;
            end
            else
                n.fw_cnt = 3'(r.fw_cnt - 3'h1);
        end

        // Power state machine.
        case (r.st)
            ST_WARM, ST_WAKE:
            begin
                if (r.warm_cnt < ((r.st == ST_WARM) ? `WARM_FAST_RESET : `WARM_FAST_WAKE))
                    n.warm_cnt = 12'(r.warm_cnt + 12'h001);
                else if (r.slow_cnt < `WARM_SLOW)
                begin
                    if (slow_edge)
                        n.slow_cnt = 3'(r.slow_cnt + 3'h1);
                end
                else
                begin
                    n.st = ST_RUN;
                    n.div_cnt = '0;
                end
            end
            ST_RUN:
            begin
                if (r.stop_bit)
                    n.st = ST_STOP;
                else if (r.idle_bit)
                    n.st = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (wake_pin || irq_event)
                begin
                    n.st = ST_RUN;
                    n.idle_bit = 1'b0;
                end
            end
            ST_STOP:
            begin
                if (wake_pin)
                begin
                    n.st = ST_WAKE;
                    n.stop_bit = 1'b0;
                    n.warm_cnt = '0;
                    n.slow_cnt = '0;
                end
            end
            default:
                n.st = ST_WARM;
        endcase

        // Register writes come last so a write wins over a hardware clear.
        if (wr_en)
        begin
            case (idx)
                `IDX_FETCH_WAIT:
                    n.fw = pwdata[`FW_MSB:`FW_LSB];
                `IDX_DIV_SELECT:
                    n.div_sel = pwdata[`DIV_MSB:0];
                `IDX_DIV_APPLY:
                begin
                    // Reserved codes and other values leave the divider as is.
                    if (apply_hit && (r.div_sel <= `DIV_CODE_MAX))
                    begin
                        n.div_act = r.div_sel;
                        n.div_cnt = '0;
                        n.gap_ok = 1'b0;
                    end
                end
                `IDX_PWR_CTRL:
                begin
                    n.idle_bit = pwdata[`PC_IDLE_BIT];
                    n.stop_bit = pwdata[`PC_STOP_BIT];
                    n.gf0 = pwdata[`PC_GF0_BIT];
                end
                `IDX_P1_WAKE:
                    n.p1w = pwdata[7:0];
                default:
                    n.p1w = r.p1w;
            endcase
        end

        // Read data is captured in the setup phase and held through access.
        if (setup)
            n.prdata = rd_mux;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register with reset values.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.st <= ST_WARM;
            r.fw <= `FW_RESET;
            r.div_sel <= `DIV_SEL_RESET;
            r.div_act <= `DIV_ACT_RESET;
            r.p1w <= `P1W_RESET;
        end
        else
            r <= n;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign prdata = r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign cpu_tick = r.tick;
    assign cpu_run = (r.st == ST_RUN);
    assign periph_run = (r.st == ST_RUN) || (r.st == ST_IDLE);
    assign osc_run = periph_run;
    assign fetch_done = r.fetch_done;
    assign fetch_wait_cycles = r.fw;
    assign pwr_state = r.st;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence idle_req_s;
        wr_en && (idx == `IDX_PWR_CTRL) && pwdata[0] && !pwdata[1] && (r.st == ST_RUN);
    endsequence

    sequence stop_wake_s;
        (r.st == ST_STOP) && wake_pin;
    endsequence

    AST_DIV_ONLY_ON_APPLY: assert property (
        @(posedge pclk) disable iff (!presetn)
        $changed(r.div_act) |-> $past(apply_hit))
        else $error("Divider changed without the apply code.");

    AST_APPLY_OTHER_KEEPS: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && (idx == `IDX_DIV_APPLY) && !apply_hit |=> $stable(r.div_act))
        else $error("Non-apply write changed the divider.");

    AST_TICK_SPACING: assert property (
        @(posedge pclk) disable iff (!presetn)
        cpu_tick && r.gap_ok |-> r.gap == ratio)
        else $error("CPU tick spacing does not match the divider.");

    AST_IDLE_ENTRY: assert property (
        @(posedge pclk) disable iff (!presetn)
        idle_req_s ##1 (!wr_en && !irq_event && !wake_pin) |=> pwr_state == ST_IDLE)
        else $error("Idle request did not enter idle.");

    AST_IDLE_GATES_CPU: assert property (
        @(posedge pclk) disable iff (!presetn)
        pwr_state == ST_IDLE ##1 pwr_state == ST_IDLE |-> !cpu_tick && periph_run && osc_run)
        else $error("Idle did not gate only the CPU tick.");

    AST_IDLE_WAKE: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pwr_state == ST_IDLE) && (irq_event || wake_pin) && !wr_en
        |=> (pwr_state == ST_RUN) && !r.idle_bit)
        else $error("Idle did not wake or clear its bit.");

    AST_STOP_ALL_OFF: assert property (
        @(posedge pclk) disable iff (!presetn)
        pwr_state == ST_STOP |-> !periph_run && !osc_run && !cpu_tick && $stable(r.p1w))
        else $error("Stop left a clock running.");

    AST_STOP_IGNORES_IRQ: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pwr_state == ST_STOP) && !wake_pin |=> pwr_state == ST_STOP)
        else $error("Stop left without a port change.");

    AST_STOP_WAKE_WARM: assert property (
        @(posedge pclk) disable iff (!presetn)
        stop_wake_s |=> (pwr_state == ST_WAKE) && !r.stop_bit ##64 pwr_state == ST_WAKE)
        else $error("Stop wake did not warm up.");

    AST_WARM_COUNTS: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(pwr_state == ST_RUN) && $past(pwr_state != ST_IDLE)
        |-> $past(r.slow_cnt) == `WARM_SLOW
        && ($past(r.warm_cnt)
        == (($past(pwr_state) == ST_WARM) ? `WARM_FAST_RESET : `WARM_FAST_WAKE)))
        else $error("Warm-up ended early.");

    AST_FETCH_WAIT: assert property (
        @(posedge pclk) disable iff (!presetn)
        fetch_done |-> r.fticks == 4'({1'b0, fetch_wait_cycles} + 4'h1))
        else $error("Fetch stretch count is wrong.");

endmodule
`default_nettype wire

// ===== verilog/clk_pwr_defines.svh
`ifndef CLK_PWR_DEFINES_SVH
`define CLK_PWR_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_FETCH_WAIT 8'h8E
`define IDX_DIV_SELECT 8'hE5
`define IDX_DIV_APPLY 8'hE6
`define IDX_PWR_CTRL 8'h87
`define IDX_P1_WAKE 8'h91

// Field positions.
`define FW_MSB 6
`define FW_LSB 4
`define DIV_MSB 2
`define PC_IDLE_BIT 0
`define PC_STOP_BIT 1
`define PC_GF0_BIT 2

// Codes and reset values.
`define APPLY_CODE 8'h69
`define DIV_CODE_MAX 3'h5
`define RATIO_MAX 8'h80
`define FW_RESET 3'h7
`define FW_LOW_READ 4'h1
`define DIV_SEL_RESET 3'h7
`define DIV_ACT_RESET 3'h0
`define P1W_RESET 8'h00

// Warm-up counts in fast periods and slow oscillator edges.
`define WARM_FAST_RESET 12'h800
`define WARM_FAST_WAKE 12'h040
`define WARM_SLOW 3'h5

`endif

// ===== verilog/clk_pwr_pkg.sv
package clk_pwr_pkg;

    // Power management states, one-hot.
    typedef enum logic [4:0] {
        ST_WARM = 5'b00001,
        ST_RUN = 5'b00010,
        ST_IDLE = 5'b00100,
        ST_STOP = 5'b01000,
        ST_WAKE = 5'b10000
    } pwr_state_t;

    // Complete state of the clock and power controller.
    typedef struct packed {
        pwr_state_t st;
        logic [2:0] fw;
        logic [2:0] div_sel;
        logic [2:0] div_act;
        logic gf0;
        logic idle_bit;
        logic stop_bit;
        logic [7:0] p1w;
        logic [6:0] div_cnt;
        logic tick;
        logic fetch_busy;
        logic [2:0] fw_cnt;
        logic fetch_done;
        logic [11:0] warm_cnt;
        logic [2:0] slow_cnt;
        logic [31:0] prdata;
        logic [7:0] gap;
        logic gap_ok;
        logic [3:0] fticks;
    } core_state_t;

    // State of the pin synchroniser.
    typedef struct packed {
        logic [16:0] s1;
        logic [16:0] s2;
        logic [16:0] s3;
        logic [16:0] stable;
        logic [16:0] change;
    } sync_state_t;

endpackage

// ===== verilog/pin_change_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Brings the port pins and the slow oscillator into the pclk domain and flags changes.
module pin_change_sync
    import clk_pwr_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Raw asynchronous inputs.
    input wire logic [16:0] pins,
    // Filtered level and one-cycle change flag per input.
    output logic [16:0] stable,
    output logic [16:0] change
);
    import clk_pwr_pkg::*;

    sync_state_t r;
    sync_state_t n;

    // A change counts once the second and third stages agree on a new level.
    always_comb
    begin
        n = r;
        n.s1 = pins;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.change = '0;
        for (int i = 0; i < 17; i++)
        begin
            if ((r.s2[i] == r.s3[i]) && (r.s3[i] != r.stable[i]))
            begin
                n.stable[i] = r.s3[i];
                n.change[i] = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else
            r <= n;
    end

    assign stable = r.stable;
    assign change = r.change;

endmodule
`default_nettype wire

// ===== test/cpu_fetch_model.sv
`timescale 1ns/1ns
`default_nettype none

// Stands in for the CPU core: requests program fetches and counts the ticks each one takes.
module cpu_fetch_model
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Control from the bench.
    input wire logic go,
    // Block side.
    input wire logic cpu_run,
    input wire logic cpu_tick,
    input wire logic fetch_done,
    output logic fetch_req,
    // Observations.
    output logic [3:0] ticks_seen,
    output logic [7:0] done_cnt
);
    logic started;
    logic [3:0] cnt;

    ////////////////////////////////////////////////////////////////////////////
    // The request is a one-cycle pulse, so a request still high at the answer is never taken twice.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fetch_req <= 1'b0;
            started <= 1'b0;
            cnt <= 4'h0;
            ticks_seen <= 4'h0;
            done_cnt <= 8'h00;
        end
        else if (!fetch_req && !started)
            fetch_req <= go && cpu_run;
        else if (!started)
        begin
            fetch_req <= 1'b0;
            started <= 1'b1;
            cnt <= 4'h0;
        end
        else if (fetch_done)
        begin
            ticks_seen <= cnt;
            done_cnt <= done_cnt + 8'h01;
            started <= 1'b0;
        end
        else if (cpu_tick)
            cnt <= cnt + 4'h1;
    end
endmodule

`default_nettype wire

// ===== test/clock_divider_power_modes_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "clk_pwr_defines.svh"

module clock_divider_power_modes_bench;
    import clk_pwr_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, irq_event, slow_osc, go, pready, pslverr, err;
    logic fetch_req, fetch_done, cpu_tick, cpu_run, periph_run, osc_run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] port0_in, port1_in, done_cnt, m;
    logic [7:0] t_idx [6];
    logic [31:0] t_exp [6];
    logic [2:0] fetch_wait_cycles;
    logic [3:0] ticks_seen;
    pwr_state_t pwr_state;
    int fails, total_checks, n, p, k;

    clock_divider_power_modes u_clock_divider_power_modes (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_in(port0_in),
        .port1_in(port1_in), .internal_slow_oscillator(slow_osc), .irq_event(irq_event),
        .fetch_req(fetch_req), .fetch_done(fetch_done), .fetch_wait_cycles(fetch_wait_cycles),
        .cpu_tick(cpu_tick), .cpu_run(cpu_run), .periph_run(periph_run), .osc_run(osc_run),
        .pwr_state(pwr_state));

    cpu_fetch_model u_cpu_fetch_model (.pclk(pclk), .presetn(presetn), .go(go),
        .cpu_run(cpu_run), .cpu_tick(cpu_tick), .fetch_done(fetch_done), .fetch_req(fetch_req),
        .ticks_seen(ticks_seen), .done_cnt(done_cnt));

    ////////////////////////////////////////////////////////////////////////////
    // The oscillator clock never changes rate, and the slow oscillator runs at one sixteenth of it.
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial
    begin
        slow_osc = 1'b0;
        forever #400 slow_osc = ~slow_osc;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compares one value and reports a mismatch at once.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Cycles between two CPU ticks.
    task per();
        p = 0;
        @(negedge pclk);
        while (cpu_tick !== 1'b1) @(negedge pclk);
        do
        begin
            @(negedge pclk);
            p++;
        end while (cpu_tick !== 1'b1);
    endtask

    // Cycles until the power state is reached, bounded.
    task wait_st(input pwr_state_t s);
        n = 0;
        while (pwr_state !== s && n < 3000)
        begin
            @(negedge pclk);
            n++;
        end
    endtask

    task wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog against a hang.
    initial
    begin
        repeat (30000) @(posedge pclk);
        fails++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, divider, fetch stretch, idle and stop.
    initial
    begin
        {presetn, psel, penable, pwrite, irq_event, go} = 6'h00;
        {paddr, pwdata, port0_in, port1_in} = '0;
        fails = 0;
        total_checks = 0;
        t_idx = '{`IDX_FETCH_WAIT, `IDX_DIV_SELECT, `IDX_DIV_APPLY, `IDX_PWR_CTRL, `IDX_P1_WAKE,
            8'h10};
        t_exp = '{32'h00000071, 32'h00000007, 32'h0, 32'h0, 32'h0, 32'h80000000};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        wait_st(ST_RUN);
        chk(32'(n >= 2048 && n < 2300), 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, t_idx[i], 8'h00);
            chk({err, rd[30:0]}, t_exp[i]);
        end
        chk({29'h0, fetch_wait_cycles}, 32'h7);
        per();
        chk(p, 128);
        apb(1'b1, `IDX_DIV_SELECT, 8'h05);
        per();
        chk(p, 128);
        apb(1'b1, `IDX_DIV_APPLY, 8'h68);
        per();
        chk(p, 128);
        // Software order: select, then apply code, then the fetch stretch.
        for (int c = 0; c < 6; c++)
        begin
            apb(1'b1, `IDX_DIV_SELECT, 8'(c));
            apb(1'b1, `IDX_DIV_APPLY, `APPLY_CODE);
            per();
            chk(p, 128 >> c);
        end
        for (int w = 0; w < 8; w += 7)
        begin
            apb(1'b1, `IDX_FETCH_WAIT, {1'b0, 3'(w), 4'h0});
            apb(1'b0, `IDX_FETCH_WAIT, 8'h00);
            chk(rd, {25'h0, 3'(w), 4'h1});
            chk({29'h0, fetch_wait_cycles}, w);
            go <= 1'b1;
            m = done_cnt;
            while (8'(done_cnt - m) < 8'h02) @(negedge pclk);
            // Stop fetching so no fetch is in flight when the wait field changes.
            go <= 1'b0;
            chk({28'h0, ticks_seen}, w + 1);
        end
        apb(1'b1, `IDX_PWR_CTRL, 8'h01);
        repeat (3) @(negedge pclk);
        chk({27'h0, pwr_state}, {27'h0, ST_IDLE});
        chk({29'h0, cpu_run, periph_run, osc_run}, 32'h3);
        k = 0;
        repeat (60)
        begin
            @(negedge pclk);
            k += int'(cpu_tick === 1'b1);
        end
        chk(k, 0);
        @(posedge pclk);
        irq_event <= 1'b1;
        wait_st(ST_RUN);
        chk(32'(n < 4), 32'h1);
        @(posedge pclk);
        irq_event <= 1'b0;
        apb(1'b0, `IDX_PWR_CTRL, 8'h00);
        chk(rd, 32'h0);
        apb(1'b1, `IDX_P1_WAKE, 8'hA4);
        apb(1'b1, `IDX_PWR_CTRL, 8'h02);
        repeat (3) @(negedge pclk);
        chk({27'h0, pwr_state}, {27'h0, ST_STOP});
        chk({29'h0, cpu_run, periph_run, osc_run}, 32'h0);
        @(posedge pclk);
        irq_event <= 1'b1;
        port1_in <= 8'h01;
        repeat (30) @(negedge pclk);
        chk({27'h0, pwr_state}, {27'h0, ST_STOP});
        @(posedge pclk);
        irq_event <= 1'b0;
        port0_in <= 8'h08;
        wait_st(ST_WAKE);
        chk(32'(n < 10), 32'h1);
        wait_st(ST_RUN);
        chk(32'(n >= 64 && n < 400), 32'h1);
        apb(1'b0, `IDX_PWR_CTRL, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, `IDX_P1_WAKE, 8'h00);
        chk(rd, 32'hA4);
        apb(1'b1, `IDX_P1_WAKE, 8'hA5);
        apb(1'b1, `IDX_PWR_CTRL, 8'h02);
        repeat (3) @(negedge pclk);
        @(posedge pclk);
        port1_in <= 8'h00;
        wait_st(ST_WAKE);
        chk(32'(n < 10), 32'h1);
        wait_st(ST_RUN);
        chk({27'h0, pwr_state}, {27'h0, ST_RUN});
        // A second reset in mid-run brings back the reset values.
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk({27'h0, pwr_state}, {27'h0, ST_WARM});
        chk({29'h0, fetch_wait_cycles}, 32'h7);
        chk({29'h0, cpu_run, periph_run, osc_run}, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, `IDX_P1_WAKE, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, `IDX_DIV_SELECT, 8'h00);
        chk(rd, 32'h7);
        wrap_up();
    end
endmodule

`default_nettype wire
